// *** rtl/pcs_regs.sv ***
// Status and class code configuration registers of the host controller function
//
// Overview of operation
// - Poisoned packet received sets bit 15 always
// - Error message sent with fault enable sets 14
// - Unsupported-request completion received sets bit 13
// - Completer-abort completion received sets bit 12
// - Completer-abort returned by us sets bit 11
// - Bit 8 set on poison when response enabled
// - Status at 06h; flags sticky until cleared
// - Select timing bits 10:9 read zero
// - Bits 7, 6, 5, 2:0 read zero
// - Bit 4 reads one, capability list
// - Bit 3 mirrors live interrupt condition
// - Status reads 0010h after reset
// - Offset 08h: base 0Ch, subclass 03h
// - Programming interface 30h in bits 15:8
// - Revision byte fixed read-only in bits 7:0
`timescale 1ns/1ps
module pcs_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Configuration access port (dword address as byte offset)
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    // Configuration read answer
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // Command register enables from neighbour register
    input wire logic [15:0] cmd_value,
    // Link events, one-cycle pulses
    input wire logic rx_poisoned_tlp,
    input wire logic tx_error_message,
    input wire logic rx_cpl_unsupported,
    input wire logic rx_cpl_completer_abort,
    input wire logic tx_cpl_completer_abort,
    input wire logic rx_poisoned_cpl_data,
    input wire logic rx_write_poisoned,
    // Live interrupt condition of the function
    input wire logic function_irq,
    // Status register image
    output logic [15:0] status_value
);
    import pcs_pkg::*;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Dword-aligned address match
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        addr_hit = (a[11:2] == off[11:2]);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] rdata;
        logic rvalid;
        logic int_status;
        logic [15:0] status;
    } pcs_state_t;
    pcs_state_t st_reg;
    pcs_state_t st_next;

    // Flag wires from the sticky cells
    logic detected_poison_flag;
    logic signaled_system_fault;
    logic received_unsupported_flag;
    logic received_completer_abort;
    logic signaled_completer_abort;
    logic data_poison_flag;
    // Enables taken from the command register
    logic system_fault_enable;
    logic poison_response_enable;
    // Clear strobes, write one to clear on upper status byte lanes
    logic status_wr;
    logic [15:0] clr_bits;
    // Event set terms
    logic set_sys_fault;
    logic set_data_poison;
    // Composed status and class words
    logic [15:0] status_word;
    logic [31:0] class_word;

    assign system_fault_enable = cmd_value[PCS_CMD_SYS_FAULT_EN];
    assign poison_response_enable = cmd_value[PCS_CMD_POISON_RESP_EN];

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    // Status occupies byte lanes 3:2 of the dword at 04h
    assign status_wr = cfg_wr && addr_hit(cfg_addr, PCS_OFF_STATUS);
    // Only flag bits are clearable; read-only bits ignore writes
    assign clr_bits = status_wr ?
        ({cfg_be[3] ? cfg_wdata[31:24] : 8'h00, cfg_be[2] ? cfg_wdata[23:16] : 8'h00}
         & PCS_FLAG_MASK) : 16'h0000;

    // Gated set terms
    assign set_sys_fault = tx_error_message && system_fault_enable;
    assign set_data_poison = poison_response_enable
        && (rx_poisoned_cpl_data || rx_write_poisoned);

    // ----------------------------------------
    // Sticky event flags
    // ----------------------------------------
    // Detected poison, regardless of response enable
    pcs_flag u_det_poison (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(rx_poisoned_tlp),
        .clr_req(clr_bits[PCS_BIT_DET_POISON]),
        .flag(detected_poison_flag)
    );
    // Signaled system fault
    pcs_flag u_sys_fault (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(set_sys_fault),
        .clr_req(clr_bits[PCS_BIT_SYS_FAULT]),
        .flag(signaled_system_fault)
    );
    // Received unsupported request completion
    pcs_flag u_rcv_unsup (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(rx_cpl_unsupported),
        .clr_req(clr_bits[PCS_BIT_RCV_UNSUP]),
        .flag(received_unsupported_flag)
    );
    // Received completer abort
    pcs_flag u_rcv_ca (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(rx_cpl_completer_abort),
        .clr_req(clr_bits[PCS_BIT_RCV_CA]),
        .flag(received_completer_abort)
    );
    // Signaled completer abort
    pcs_flag u_sig_ca (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(tx_cpl_completer_abort),
        .clr_req(clr_bits[PCS_BIT_SIG_CA]),
        .flag(signaled_completer_abort)
    );
    // Data poison, gated by response enable
    pcs_flag u_data_poison (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(set_data_poison),
        .clr_req(clr_bits[PCS_BIT_DATA_POISON]),
        .flag(data_poison_flag)
    );

    // ----------------------------------------
    // Register images
    // ----------------------------------------
    // Status word assembly, hardwired bits are constants
    always_comb begin
        status_word = 16'h0000;
        status_word[PCS_BIT_DET_POISON] = detected_poison_flag;
        status_word[PCS_BIT_SYS_FAULT] = signaled_system_fault;
        status_word[PCS_BIT_RCV_UNSUP] = received_unsupported_flag;
        status_word[PCS_BIT_RCV_CA] = received_completer_abort;
        status_word[PCS_BIT_SIG_CA] = signaled_completer_abort;
        status_word[PCS_BIT_DATA_POISON] = data_poison_flag;
        status_word[PCS_BIT_CAP_CHAIN] = 1'b1;
        status_word[PCS_BIT_INT_STATUS] = st_reg.int_status;
    end

    // Class code and revision, fixed
    assign class_word = {PCS_BASE_CLASS, PCS_SUB_CLASS, PCS_PROG_IF, PCS_SILICON_REV};

    // ----------------------------------------
    // Next state and read mux
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = cfg_rd;
        // Interrupt status follows the live condition
        st_next.int_status = function_irq;
        st_next.status = status_word;
        if (cfg_rd) begin
            if (addr_hit(cfg_addr, PCS_OFF_STATUS)) begin
                // Status in upper half, command half owned elsewhere
                st_next.rdata = {status_word, 16'h0000};
            end else if (addr_hit(cfg_addr, PCS_OFF_CLASS)) begin
                st_next.rdata = class_word;
            end else begin
                // Unmapped offsets read zero
                st_next.rdata = 32'h0000_0000;
            end
        end
    end

    // Register update
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg.rdata <= 32'h0000_0000;
            st_reg.rvalid <= 1'b0;
            st_reg.int_status <= 1'b0;
            st_reg.status <= PCS_STATUS_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cfg_rdata = st_reg.rdata;
    assign cfg_rvalid = st_reg.rvalid;
    assign status_value = st_reg.status;

    // ----------------------------------------
    // Checks: flag setting
    // ----------------------------------------
    // Poisoned packet shows in the image two edges later
    chk_poison_sets: assert property (@(posedge clk) disable iff (sys_rst)
        rx_poisoned_tlp |=> ##1 status_value[PCS_BIT_DET_POISON])
        else $error("poison flag missing");
    // No poison flag without a poisoned packet
    chk_poison_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        (!detected_poison_flag && !rx_poisoned_tlp) |=> !detected_poison_flag)
        else $error("poison flag set without event");
    // Error message with fault enable raises the fault flag
    chk_fault_sets: assert property (@(posedge clk) disable iff (sys_rst)
        (tx_error_message && cmd_value[PCS_CMD_SYS_FAULT_EN])
        |=> ##1 status_value[PCS_BIT_SYS_FAULT])
        else $error("fault flag missing");
    // Fault flag stays clear while messages are gated off
    chk_fault_gated: assert property (@(posedge clk) disable iff (sys_rst)
        (!signaled_system_fault && !(tx_error_message && cmd_value[PCS_CMD_SYS_FAULT_EN]))
        |=> !signaled_system_fault)
        else $error("fault flag set while gated");
    // Unsupported completion raises its flag
    chk_unsup_sets: assert property (@(posedge clk) disable iff (sys_rst)
        rx_cpl_unsupported |=> ##1 status_value[PCS_BIT_RCV_UNSUP])
        else $error("unsupported flag missing");
    // No unsupported flag without its completion
    chk_unsup_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        (!received_unsupported_flag && !rx_cpl_unsupported) |=> !received_unsupported_flag)
        else $error("unsupported flag set without event");
    // Completer abort received raises its flag
    chk_rcv_ca_sets: assert property (@(posedge clk) disable iff (sys_rst)
        rx_cpl_completer_abort |=> ##1 status_value[PCS_BIT_RCV_CA])
        else $error("rcv abort missing");
    // No received abort flag without its completion
    chk_rcv_ca_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        (!received_completer_abort && !rx_cpl_completer_abort) |=> !received_completer_abort)
        else $error("rcv abort set without event");
    // Completer abort returned raises its flag
    chk_sig_ca_sets: assert property (@(posedge clk) disable iff (sys_rst)
        tx_cpl_completer_abort |=> ##1 status_value[PCS_BIT_SIG_CA])
        else $error("sig abort missing");
    // No signaled abort flag without a returned abort
    chk_sig_ca_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        (!signaled_completer_abort && !tx_cpl_completer_abort) |=> !signaled_completer_abort)
        else $error("sig abort set without event");
    // Poisoned data with response enabled raises the data flag
    chk_data_sets: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_value[PCS_CMD_POISON_RESP_EN] && (rx_poisoned_cpl_data || rx_write_poisoned))
        |=> ##1 status_value[PCS_BIT_DATA_POISON])
        else $error("data poison flag missing");
    // Data flag stays clear when disabled or without poisoned data
    chk_data_gate: assert property (@(posedge clk) disable iff (sys_rst)
        (!data_poison_flag && !(cmd_value[PCS_CMD_POISON_RESP_EN]
        && (rx_poisoned_cpl_data || rx_write_poisoned))) |=> !data_poison_flag)
        else $error("data poison set while gated");

    // ----------------------------------------
    // Checks: flag clearing
    // ----------------------------------------
    // Write to the status dword with the flag byte lane enabled
    logic chk_clr_lane;
    assign chk_clr_lane = cfg_wr && (cfg_addr[11:2] == PCS_OFF_STATUS[11:2]) && cfg_be[3];
    // A one clears the poison flag unless a new packet lands
    chk_clear_poison: assert property (@(posedge clk) disable iff (sys_rst)
        (chk_clr_lane && cfg_wdata[16 + PCS_BIT_DET_POISON] && !rx_poisoned_tlp)
        |=> !detected_poison_flag)
        else $error("poison flag not cleared");
    // A one clears the fault flag unless a new message goes out
    chk_clear_fault: assert property (@(posedge clk) disable iff (sys_rst)
        (chk_clr_lane && cfg_wdata[16 + PCS_BIT_SYS_FAULT] && !set_sys_fault)
        |=> !signaled_system_fault)
        else $error("fault flag not cleared");
    // A one clears the unsupported flag
    chk_clear_unsup: assert property (@(posedge clk) disable iff (sys_rst)
        (chk_clr_lane && cfg_wdata[16 + PCS_BIT_RCV_UNSUP] && !rx_cpl_unsupported)
        |=> !received_unsupported_flag)
        else $error("unsupported flag not cleared");
    // A one clears the received abort flag
    chk_clear_rcv_ca: assert property (@(posedge clk) disable iff (sys_rst)
        (chk_clr_lane && cfg_wdata[16 + PCS_BIT_RCV_CA] && !rx_cpl_completer_abort)
        |=> !received_completer_abort)
        else $error("rcv abort not cleared");
    // A one clears the signaled abort flag
    chk_clear_sig_ca: assert property (@(posedge clk) disable iff (sys_rst)
        (chk_clr_lane && cfg_wdata[16 + PCS_BIT_SIG_CA] && !tx_cpl_completer_abort)
        |=> !signaled_completer_abort)
        else $error("sig abort not cleared");
    // A one clears the data poison flag
    chk_clear_data: assert property (@(posedge clk) disable iff (sys_rst)
        (chk_clr_lane && cfg_wdata[16 + PCS_BIT_DATA_POISON] && !set_data_poison)
        |=> !data_poison_flag)
        else $error("data poison not cleared");

    // ----------------------------------------
    // Checks: fixed bits and read path
    // ----------------------------------------
    // Hardwired zero bits never read one
    chk_fixed_bits: assert property (@(posedge clk) disable iff (sys_rst)
        (status_value & 16'h06E7) == 16'h0000)
        else $error("hardwired status bits wrong");
    // Capability chain bit always reads one
    chk_cap_bit: assert property (@(posedge clk) disable iff (sys_rst)
        status_value[PCS_BIT_CAP_CHAIN])
        else $error("capability bit clear");
    // Interrupt status rises behind the live condition
    chk_int_follow: assert property (@(posedge clk) disable iff (sys_rst)
        function_irq |=> ##1 status_value[PCS_BIT_INT_STATUS])
        else $error("interrupt status lag");
    // Interrupt status falls behind the live condition
    chk_int_drops: assert property (@(posedge clk) disable iff (sys_rst)
        !function_irq |=> ##1 !status_value[PCS_BIT_INT_STATUS])
        else $error("interrupt status stuck");
    // Status read returns the image in the upper half
    chk_status_read: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_rd && cfg_addr[11:2] == PCS_OFF_STATUS[11:2])
        |=> cfg_rdata == {status_value, 16'h0000})
        else $error("status read wrong");
    // Class read returns the fixed identity word
    chk_class_read: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_rd && cfg_addr[11:2] == PCS_OFF_CLASS[11:2]) |=> (cfg_rvalid
        && cfg_rdata == {PCS_BASE_CLASS, PCS_SUB_CLASS, PCS_PROG_IF, PCS_SILICON_REV}))
        else $error("class read wrong");
    // Other offsets read zero
    chk_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_rd && cfg_addr[11:2] != PCS_OFF_STATUS[11:2]
        && cfg_addr[11:2] != PCS_OFF_CLASS[11:2]) |=> cfg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // Valid follows each read one edge later
    chk_rvalid_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        cfg_rd |=> cfg_rvalid)
        else $error("read valid missing");
    // No valid without a read
    chk_rvalid_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg_rd |=> !cfg_rvalid)
        else $error("read valid without read");
    // Read data holds across writes and idle cycles
    chk_rdata_holds: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg_rd |=> $stable(cfg_rdata))
        else $error("read data changed without read");
    // Reset leaves the documented image and no valid
    chk_reset_value: assert property (@(posedge clk)
        $past(sys_rst) |-> (status_value == PCS_STATUS_RESET && !cfg_rvalid))
        else $error("status reset value");
endmodule

// *** include/pcs_pkg.sv ***
// Package for the configuration status and class code register bank
package pcs_pkg;
    // ----------------------------------------
    // Register offsets (configuration byte offsets)
    // ----------------------------------------
    localparam logic [11:0] PCS_OFF_STATUS = 12'h006;
    localparam logic [11:0] PCS_OFF_CLASS = 12'h008;
    // ----------------------------------------
    // Status register field positions
    // ----------------------------------------
    localparam int PCS_BIT_DET_POISON = 15;
    localparam int PCS_BIT_SYS_FAULT = 14;
    localparam int PCS_BIT_RCV_UNSUP = 13;
    localparam int PCS_BIT_RCV_CA = 12;
    localparam int PCS_BIT_SIG_CA = 11;
    localparam int PCS_BIT_DATA_POISON = 8;
    localparam int PCS_BIT_CAP_CHAIN = 4;
    localparam int PCS_BIT_INT_STATUS = 3;
    // Command register enable positions (neighbour register)
    localparam int PCS_CMD_SYS_FAULT_EN = 8;
    localparam int PCS_CMD_POISON_RESP_EN = 6;
    // Mask of event flags that software clears by writing one
    localparam logic [15:0] PCS_FLAG_MASK = 16'hF900;
    // ----------------------------------------
    // Reset values and constants
    // ----------------------------------------
    localparam logic [15:0] PCS_STATUS_RESET = 16'h0010;
    localparam logic [7:0] PCS_BASE_CLASS = 8'h0C;
    localparam logic [7:0] PCS_SUB_CLASS = 8'h03;
    localparam logic [7:0] PCS_PROG_IF = 8'h30;
    // Silicon revision; value is arbitrary
    localparam logic [7:0] PCS_SILICON_REV = 8'h5A;
endpackage

// *** rtl/pcs_flag.sv ***
// One sticky event flag with write-one-to-clear, set wins over clear
`timescale 1ns/1ps
module pcs_flag (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Event and clear
    input wire logic set_evt,
    input wire logic clr_req,
    // Flag value
    output logic flag
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic flag;
    } pcs_flag_state_t;
    pcs_flag_state_t st_reg;
    pcs_flag_state_t st_next;

    // Next-state: set beats clear in the same cycle
    always_comb begin
        st_next = st_reg;
        if (set_evt) begin
            st_next.flag = 1'b1;
        end else if (clr_req) begin
            st_next.flag = 1'b0;
        end
    end

    // Register update
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag = st_reg.flag;

    // Set event always leaves the flag set
    chk_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
        set_evt |=> flag)
        else $error("flag not set after event");
    // Flag holds without a clear
    chk_flag_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (flag && !clr_req) |=> flag)
        else $error("flag dropped without clear");
endmodule

// *** testbench/pcs_host_model.sv ***
// Root complex model issuing configuration reads and writes
`timescale 1ns/1ps
module pcs_host_model (
    // Clock
    input wire logic clk,
    // Request lines
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [11:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    // Answer lines
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    // Idle bus at time zero
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 12'h000;
        cfg_be = 4'h0;
        cfg_wdata = 32'h00000000;
    end
    // Read: one request edge, data taken while the valid pulse stands
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        d = 'x;
        @(negedge clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd = 1'b0;
        cfg_addr = ~a;
        // Valid already stands here; look before the next edge drops it
        for (int n = 0; n < 4; n++) begin
            if (cfg_rvalid === 1'b1) begin
                d = cfg_rdata;
                break;
            end
            @(negedge clk);
        end
    endtask
    // Write: released qualifiers turn to their inverse so stale values never match
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
        cfg_addr = ~a;
        cfg_be = ~be;
        cfg_wdata = ~d;
    endtask
endmodule

// *** testbench/pcie_config_status_class_bench.sv ***
// Self-checking bench for the status and class code registers
`timescale 1ns/1ps
module pcie_config_status_class_bench;
    import pcs_pkg::*;
    // Stimulus and bus signals
    logic clk, sys_rst, function_irq, cfg_rd, cfg_wr, cfg_rvalid;
    logic [6:0] evt, e;
    logic [11:0] cfg_addr;
    logic [3:0] cfg_be, be;
    logic [15:0] cmd_value, status_value, exp_flags, dc;
    logic [31:0] cfg_wdata, cfg_rdata, r32;
    // Bookkeeping
    int bad_count, samples_checked, cycles;
    integer seed;
    pcs_regs uut (.clk(clk), .sys_rst(sys_rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .cmd_value(cmd_value), .rx_poisoned_tlp(evt[0]),
        .tx_error_message(evt[1]), .rx_cpl_unsupported(evt[2]),
        .rx_cpl_completer_abort(evt[3]), .tx_cpl_completer_abort(evt[4]),
        .rx_poisoned_cpl_data(evt[5]), .rx_write_poisoned(evt[6]),
        .function_irq(function_irq), .status_value(status_value));
    pcs_host_model host (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
    // Flags that a set of events must raise under a command value
    function automatic logic [15:0] evt_flags(input logic [6:0] x, input logic [15:0] c);
        logic [15:0] f;
        f = 16'h0000;
        f[PCS_BIT_DET_POISON] = x[0];
        f[PCS_BIT_SYS_FAULT] = x[1] & c[PCS_CMD_SYS_FAULT_EN];
        f[PCS_BIT_RCV_UNSUP] = x[2];
        f[PCS_BIT_RCV_CA] = x[3];
        f[PCS_BIT_SIG_CA] = x[4];
        f[PCS_BIT_DATA_POISON] = (x[5] | x[6]) & c[PCS_CMD_POISON_RESP_EN];
        return f;
    endfunction
    // Read one offset and compare the masked answer
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
            input logic [31:0] m);
        logic [31:0] d;
        host.rd(a, d);
        samples_checked++;
        if ((d & m) !== (exp & m)) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp & m, d & m);
        end
    endtask
    // Compare the status image port
    task automatic sv_chk(input string what, input logic [15:0] exp);
        samples_checked++;
        if ((status_value & ~dc) !== (exp & ~dc)) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, status_value);
        end
    endtask
    // Status read plus image, both against the expected flags
    task automatic st_chk(input string what);
        rd_chk(what, PCS_OFF_STATUS, {exp_flags | 16'h0010, 16'h0000}, {~dc, 16'hFFFF});
        sv_chk(what, exp_flags | 16'h0010);
    endtask
    // One-cycle event pulse
    task automatic pulse(input logic [6:0] x);
        @(negedge clk);
        evt = x;
        @(negedge clk);
        evt = 7'h00;
    endtask
    // Count report and verdict
    task automatic summarize();
        $display("Checks made %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            summarize();
        end
    end
    // Main sequence
    initial begin
        seed = 18;
        sys_rst = 1'b1;
        evt = 7'h00;
        cmd_value = 16'h0000;
        function_irq = 1'b0;
        exp_flags = 16'h0000;
        dc = 16'h0000;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        // Reset values and identity fields
        st_chk("status after reset");
        rd_chk("class base and sub", PCS_OFF_CLASS, 32'h0C030000, 32'hFFFF0000);
        rd_chk("class prog if", PCS_OFF_CLASS, 32'h00003000, 32'h0000FF00);
        rd_chk("revision", PCS_OFF_CLASS, {24'h000000, PCS_SILICON_REV}, 32'h000000FF);
        rd_chk("unmapped", 12'h00C, 32'h00000000, 32'hFFFFFFFF);
        $display("Test done: reset values");
        // Ones written to hardwired bits must not stick
        host.wr(PCS_OFF_CLASS, 4'hF, 32'hFFFFFFFF);
        host.wr(PCS_OFF_STATUS, 4'hF, 32'hFFFFFFFF);
        st_chk("status after ro write");
        rd_chk("class after write", PCS_OFF_CLASS, {24'h0C0330, PCS_SILICON_REV}, '1);
        $display("Test done: read-only writes");
        // Each event alone, enables off and on
        for (int k = 0; k < 14; k++) begin
            cmd_value = (k[0] ? 16'h0140 : 16'h0000) | (16'($random(seed)) & 16'hFEBF);
            e = 7'h01 << (k / 2);
            pulse(e);
            exp_flags = evt_flags(e, cmd_value);
            dc = (e[5] | e[6]) ? 16'h8000 : 16'h0000;
            st_chk("single event");
            host.wr(PCS_OFF_STATUS, 4'hC, 32'hF9000000);
            exp_flags = 16'h0000;
            dc = 16'h0000;
            st_chk("after clear");
        end
        $display("Test done: event table");
        // Random events and partial clears, some to an unmapped offset
        for (int i = 0; i < 40; i++) begin
            cmd_value = 16'($random(seed));
            e = (i == 0) ? 7'h7F : 7'($random(seed));
            pulse(e);
            exp_flags |= evt_flags(e, cmd_value);
            if (e[5] | e[6]) dc[15] = 1'b1;
            r32 = $random(seed);
            be = 4'($random(seed));
            host.wr(r32[0] ? PCS_OFF_STATUS : 12'h00C, be, r32);
            if (r32[0] & be[3]) begin
                exp_flags &= ~(r32[31:16] & PCS_FLAG_MASK);
                dc &= ~r32[31:16];
            end
            st_chk("random status");
        end
        $display("Test done: random events");
        // Live interrupt bit follows the level both ways
        host.wr(PCS_OFF_STATUS, 4'hC, 32'hF9000000);
        dc = 16'h0000;
        function_irq = 1'b1;
        @(negedge clk);
        exp_flags = 16'h0008;
        st_chk("irq high");
        function_irq = 1'b0;
        @(negedge clk);
        exp_flags = 16'h0000;
        st_chk("irq low");
        $display("Test done: interrupt status");
        // Reset in mid-run drops every flag set before it
        cmd_value = 16'h0140;
        pulse(7'h7F);
        exp_flags = evt_flags(7'h7F, cmd_value);
        st_chk("flags before reset");
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        exp_flags = 16'h0000;
        st_chk("status after second reset");
        $display("Test done: mid-run reset");
        summarize();
    end
endmodule
